// ---- system_control_status_pkg.sv ----
// constants, field positions and state types shared by the control word
// block; assumes a 32-bit apb bus with a 12-bit byte address
`default_nettype none

package system_control_status_pkg;

  // printed offsets are word indices, so the byte address is four times them
  localparam logic [9:0]  SYSTEM_CONTROL_STATUS_IDX   = 10'h180;
  localparam logic [9:0]  IRQ_STAT_IDX  = 10'h1f0;
  localparam logic [9:0]  IRQ_MASK_IDX  = 10'h1f1;
  localparam logic [9:0]  CHKSUM_IDX    = 10'h1f2;
  localparam logic [1:0]  WORD_ALIGN    = 2'h0;

  localparam int          CTRL_W        = 9;
  localparam int          MIRROR_LO     = 16;
  localparam int          MIRROR_HI     = 24;
  localparam int          BIT_EMPTY23   = 23;
  localparam int          BIT_REF       = 21;
  localparam int          BIT_SC        = 20;
  localparam int          BIT_CHK       = 19;
  localparam int          BIT_DET       = 18;
  localparam int          BIT_SIGN      = 17;
  localparam int          RESV_HI       = 15;
  localparam int          RESV_LO       = 9;

  localparam logic [8:0]  CTRL_RST      = 9'h004;
  localparam logic [8:0]  MIRROR_RST    = 9'h000;
  localparam logic [31:0] ALL_ONES      = 32'hffffffff;
  localparam logic [31:0] CHKSUM_RST    = 32'h00000000;
  localparam logic [2:0]  DETECT_RUN    = 3'h4;

  localparam int          IRQ_W         = 4;
  localparam int          IRQ_REF       = 0;
  localparam int          IRQ_SC        = 1;
  localparam int          IRQ_CHK       = 2;
  localparam int          IRQ_DET       = 3;

  localparam int          SYNC_W        = 4;
  localparam int          SY_REF        = 0;
  localparam int          SY_ABOVE      = 1;
  localparam int          SY_STROBE     = 2;
  localparam int          SY_NEG        = 3;

  typedef struct packed {
    logic [SYNC_W-1:0] first;
    logic [SYNC_W-1:0] second;
  } sync_state_t;

  typedef struct packed {
    logic [8:0]       ctrl_r;
    logic [8:0]       mirror_r;
    logic             ref_r;
    logic             sc_r;
    logic             chk_r;
    logic             det_r;
    logic             sign_r;
    logic [2:0]       run_r;
    logic             strobe_d_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [31:0]      chksum_r;
    logic             pready_r;
    logic             pslverr_r;
    logic [31:0]      prdata_r;
    logic             irq_r;
  } ctl_state_t;

endpackage

`default_nettype wire

// ---- system_control_status_sync.sv ----
// two-stage synchroniser for the analog status pins
// assumes the pins are slow levels; only the second stage is read outside
`default_nettype none

module system_control_status_sync
  import system_control_status_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [SYNC_W-1:0] async_i,
  output var  logic [SYNC_W-1:0] sync_o
);

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.first  = async_i;
    st_nxt.second = st_r.first;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.second;

endmodule

`default_nettype wire

// ---- system_control_status_status.sv ----
// system control word, upper half: self-check mirror and status flags,
// with an apb slave, sticky interrupt status and a checksum register.
// assumes analog status pins are asynchronous and CFG_SUM_I is the
// same-clock sum of the calibration, metering, analog and reserved words.
//
// Notes on behaviour
// - the leakage flag follows the reference capacitor leakage pin and no bus access changes it.
// - the self-check fail flag reads 0 only when the mirror field is the bitwise inverse of the low nine bits.
// - the self-check fail flag is 1 after reset until the mirror holds the exact inverse.
// - the checksum fail flag is 0 when the configuration sum plus the checksum register is all ones.
// - a run of consecutive current samples above threshold sets the detection flag.
// - the detection flag clears only on a write of 0 while the current is below threshold.
// - the polarity flag follows the voltage sign, 1 for negative, reset 0.
// - bit 16 is writable as the mirror of bit 0 and its read value means nothing.
// - bits 15 to 9 are read-only and read as zero.
// - bits 8 to 5 store written values, reset 0, used by the self-check and driven out on CTRL_WORD_O.
`default_nettype none

module system_control_status_status
  import system_control_status_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output var  logic [31:0] PRDATA_O,
  output var  logic        PREADY_O,
  output var  logic        PSLVERR_O,
  input  wire logic        REF_LEAK_I,
  input  wire logic        CUR_ABOVE_I,
  input  wire logic        CUR_STROBE_I,
  input  wire logic        VOLT_NEG_I,
  input  wire logic [31:0] CFG_SUM_I,
  output var  logic [8:0]  CTRL_WORD_O,
  output var  logic        SELFCHECK_FAIL_O,
  output var  logic        IRQ_O
);

  ctl_state_t        s_r;
  ctl_state_t        s_nxt;
  logic [SYNC_W-1:0] pins_s;
  logic              strobe_edge;
  logic              above_s;
  logic              det_set;
  logic              setup;
  logic              access;
  logic              wr;
  logic              aligned;
  logic              hit_sys;
  logic              hit_stat;
  logic              hit_mask;
  logic              hit_sum;
  logic [31:0]       sys_rd;
  logic [31:0]       sum_all;

  system_control_status_sync u_sync (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RESET_I),
    .async_i ({VOLT_NEG_I, CUR_STROBE_I, CUR_ABOVE_I, REF_LEAK_I}),
    .sync_o  (pins_s)
  );

  assign above_s     = pins_s[SY_ABOVE];
  assign strobe_edge = pins_s[SY_STROBE] & ~s_r.strobe_d_r;
  // the run counter saturates one short, so the sample that completes the
  // run is the one that fires the set
  assign det_set     = strobe_edge & above_s
                     & (s_r.run_r == DETECT_RUN - 3'h1);
  assign sum_all     = 32'(CFG_SUM_I + s_r.chksum_r);

  assign setup    = PSEL_I & ~PENABLE_I;
  assign access   = PSEL_I & PENABLE_I & s_r.pready_r;
  assign wr       = access & PWRITE_I;
  assign aligned  = (PADDR_I[1:0] == WORD_ALIGN);
  assign hit_sys  = aligned & (PADDR_I[11:2] == SYSTEM_CONTROL_STATUS_IDX);
  assign hit_stat = aligned & (PADDR_I[11:2] == IRQ_STAT_IDX);
  assign hit_mask = aligned & (PADDR_I[11:2] == IRQ_MASK_IDX);
  assign hit_sum  = aligned & (PADDR_I[11:2] == CHKSUM_IDX);

  // read view of the control word: flags overlay the mirror positions
  always_comb begin
    sys_rd                         = '0;
    sys_rd[CTRL_W-1:0]             = s_r.ctrl_r;
    sys_rd[MIRROR_HI:MIRROR_LO]    = s_r.mirror_r;
    sys_rd[BIT_EMPTY23]            = 1'b0;
    sys_rd[BIT_REF]                = s_r.ref_r;
    sys_rd[BIT_SC]                 = s_r.sc_r;
    sys_rd[BIT_CHK]                = s_r.chk_r;
    sys_rd[BIT_DET]                = s_r.det_r;
    sys_rd[BIT_SIGN]               = s_r.sign_r;
    sys_rd[RESV_HI:RESV_LO]        = '0;
  end

  always_comb begin
    s_nxt            = s_r;
    s_nxt.strobe_d_r = pins_s[SY_STROBE];

    // apb: ready is raised for the access cycle right after setup
    s_nxt.pready_r   = setup;
    s_nxt.pslverr_r  = setup & ~(hit_sys | hit_stat | hit_mask | hit_sum);
    s_nxt.prdata_r   = '0;
    if (setup && !PWRITE_I) begin
      if (hit_sys) begin
        s_nxt.prdata_r = sys_rd;
      end else if (hit_stat) begin
        s_nxt.prdata_r[IRQ_W-1:0] = s_r.irq_stat_r;
      end else if (hit_mask) begin
        s_nxt.prdata_r[IRQ_W-1:0] = s_r.irq_mask_r;
      end else if (hit_sum) begin
        s_nxt.prdata_r = s_r.chksum_r;
      end
    end

    if (wr && hit_sys) begin
      s_nxt.ctrl_r   = PWDATA_I[CTRL_W-1:0];
      s_nxt.mirror_r = PWDATA_I[MIRROR_HI:MIRROR_LO];
    end
    if (wr && hit_mask) begin
      s_nxt.irq_mask_r = PWDATA_I[IRQ_W-1:0];
    end
    if (wr && hit_sum) begin
      s_nxt.chksum_r = PWDATA_I;
    end

    // level flags follow the pins only; bus writes never touch them
    s_nxt.ref_r  = pins_s[SY_REF];
    s_nxt.sign_r = pins_s[SY_NEG];
    // recomputed each cycle from the stored fields and CFG_SUM_I, no trigger needed
    s_nxt.sc_r   = (s_r.ctrl_r != ~s_r.mirror_r);
    s_nxt.chk_r  = (sum_all != ALL_ONES);

    if (strobe_edge) begin
      if (!above_s) begin
        s_nxt.run_r = '0;
      end else if (s_r.run_r != DETECT_RUN - 3'h1) begin
        s_nxt.run_r = 3'(s_r.run_r + 3'h1);
      end
    end
    // a clear attempted while current is still present is ignored, and a
    // set in the same cycle wins over the clear
    if (wr && hit_sys && !PWDATA_I[BIT_DET] && !above_s) begin
      s_nxt.det_r = 1'b0;
    end
    if (det_set) begin
      s_nxt.det_r = 1'b1;
    end

    if (wr && hit_stat) begin
      s_nxt.irq_stat_r = s_r.irq_stat_r & ~PWDATA_I[IRQ_W-1:0];
    end
    s_nxt.irq_stat_r[IRQ_REF] = s_nxt.irq_stat_r[IRQ_REF]
                              | (s_nxt.ref_r & ~s_r.ref_r);
    s_nxt.irq_stat_r[IRQ_SC]  = s_nxt.irq_stat_r[IRQ_SC]
                              | (s_nxt.sc_r & ~s_r.sc_r);
    s_nxt.irq_stat_r[IRQ_CHK] = s_nxt.irq_stat_r[IRQ_CHK]
                              | (s_nxt.chk_r & ~s_r.chk_r);
    s_nxt.irq_stat_r[IRQ_DET] = s_nxt.irq_stat_r[IRQ_DET] | det_set;
    s_nxt.irq_r = |(s_nxt.irq_stat_r & s_nxt.irq_mask_r);
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      s_r            <= '0;
      s_r.ctrl_r     <= CTRL_RST;
      s_r.mirror_r   <= MIRROR_RST;
      s_r.sc_r       <= 1'b1;
      s_r.chksum_r   <= CHKSUM_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O         = s_r.prdata_r;
  assign PREADY_O         = s_r.pready_r;
  assign PSLVERR_O        = s_r.pslverr_r;
  assign CTRL_WORD_O      = s_r.ctrl_r;
  assign SELFCHECK_FAIL_O = s_r.sc_r;
  assign IRQ_O            = s_r.irq_r;

  // checks

  ref_follow_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    s_r.ref_r == $past(pins_s[SY_REF]))
    else $error("leak flag does not follow pin");

  selfchk_cmp_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (wr && hit_sys) |-> ##2
      s_r.sc_r == ($past(PWDATA_I[CTRL_W-1:0], 2)
                   != ~$past(PWDATA_I[MIRROR_HI:MIRROR_LO], 2)))
    else $error("self-check flag wrong after write");

  selfchk_rst_a: assert property (@(posedge CLK_SYS_I)
    $past(RESET_I) |-> s_r.sc_r)
    else $error("self-check flag not set after reset");

  chksum_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $stable(sum_all) |=> s_r.chk_r == ($past(sum_all) != ALL_ONES))
    else $error("checksum flag wrong");

  detect_set_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    det_set |=> s_r.det_r && s_r.irq_stat_r[IRQ_DET])
    else $error("detection flag not set");

  detect_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (s_r.det_r && !(wr && hit_sys && !above_s)) |=> s_r.det_r)
    else $error("detection flag dropped without clear");

  polarity_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(pins_s[SY_NEG]) |=> s_r.sign_r ##0 $past(!s_r.sign_r))
    else $error("polarity flag does not follow sign");

  resv_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (setup && !PWRITE_I && hit_sys) |=>
      PRDATA_O[RESV_HI:RESV_LO] == '0 && PREADY_O)
    else $error("reserved bits not zero");

  resv_store_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (wr && hit_sys) |=> s_r.ctrl_r == $past(PWDATA_I[CTRL_W-1:0])
      && s_r.mirror_r == $past(PWDATA_I[MIRROR_HI:MIRROR_LO]))
    else $error("control word not stored");

  irq_out_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    IRQ_O == |(s_r.irq_stat_r & s_r.irq_mask_r))
    else $error("interrupt output mismatch");

  ready_pulse_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    setup |=> PREADY_O ##1 !PREADY_O)
    else $error("ready is not a one-cycle pulse after setup");

  err_decode_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (setup && !(hit_sys || hit_stat || hit_mask || hit_sum)) |=>
      PSLVERR_O && PREADY_O && PRDATA_O == '0)
    else $error("unmapped access not refused");

  err_pair_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    PSLVERR_O |-> PREADY_O)
    else $error("error raised outside the access cycle");

  rdata_idle_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !PREADY_O |-> PRDATA_O == '0)
    else $error("read data not zero outside the access cycle");

  bad_write_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (wr && !aligned) |=> $stable(s_r.ctrl_r) && $stable(s_r.mirror_r)
      && $stable(s_r.chksum_r) && $stable(s_r.irq_mask_r))
    else $error("refused write changed a register");

  ctrl_hold_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    !(wr && hit_sys) |=> $stable(s_r.ctrl_r) && $stable(s_r.mirror_r))
    else $error("control word changed without a write");

  sc_read_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (setup && !PWRITE_I && hit_sys) |=>
      PRDATA_O[BIT_SC] == $past(s_r.sc_r))
    else $error("self-check flag read wrong");

  sc_hold_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (s_r.sc_r && s_r.ctrl_r != ~s_r.mirror_r) |=> s_r.sc_r)
    else $error("self-check flag cleared without inverse");

  ref_steady_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    $stable(pins_s[SY_REF]) |=> $stable(s_r.ref_r))
    else $error("leak flag moved without its pin");

  sign_fall_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    $fell(pins_s[SY_NEG]) |=> !s_r.sign_r)
    else $error("polarity flag stuck negative");

  det_rise_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (!s_r.det_r && !det_set) |=> !s_r.det_r)
    else $error("detection flag set without a run");

  det_clear_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (s_r.det_r && wr && hit_sys && !PWDATA_I[BIT_DET] && !above_s
      && !det_set) |=> !s_r.det_r)
    else $error("detection flag not cleared");

  det_keep_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (s_r.det_r && wr && hit_sys && PWDATA_I[BIT_DET]) |=> s_r.det_r)
    else $error("writing one cleared the detection flag");

  sum_store_a: assert property (
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (wr && hit_sum) |=> s_r.chksum_r == $past(PWDATA_I))
    else $error("checksum register not stored");

  mask_store_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (wr && hit_mask) |=> s_r.irq_mask_r == $past(PWDATA_I[IRQ_W-1:0]))
    else $error("interrupt mask not stored");

  stat_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (wr && hit_stat && PWDATA_I[IRQ_DET] && !det_set) |=>
      !s_r.irq_stat_r[IRQ_DET])
    else $error("status bit not cleared by writing one");

endmodule

`default_nettype wire

// ---- system_control_status_status_note_end.sv ----
`default_nettype none
`default_nettype wire

// ---- system_control_status_status_tb_top.sv ----
// self-checking bench for the control word status block
// assumes a one-wait-free apb slave and pins that pass two sync flops
`default_nettype none

module system_control_status_status_tb_top
  import system_control_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] CW_A  = {SYSTEM_CONTROL_STATUS_IDX, WORD_ALIGN};
  localparam logic [11:0] ST_A  = {IRQ_STAT_IDX, WORD_ALIGN};
  localparam logic [11:0] MK_A  = {IRQ_MASK_IDX, WORD_ALIGN};
  localparam logic [11:0] SUM_A = {CHKSUM_IDX, WORD_ALIGN};

  logic        clk, rst, psel, pen, pwr, pready, pslverr, irq;
  logic        leak, above, strobe, neg, sc_fail;
  logic        refl, chkf, det, sgn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg_sum, k;
  logic [8:0]  ctrl_word, ctl, mir, c;
  logic [64:0] nt;
  logic [64:0] notes[$];
  int          failures, n_checks, cyc;

  system_control_status_status DUT (
    .CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .REF_LEAK_I(leak), .CUR_ABOVE_I(above), .CUR_STROBE_I(strobe),
    .VOLT_NEG_I(neg), .CFG_SUM_I(cfg_sum), .CTRL_WORD_O(ctrl_word),
    .SELFCHECK_FAIL_O(sc_fail), .IRQ_O(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hang counts as a mismatch; the run needs well under 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // every transfer leaves a note {error, data, mask}; compared on ready
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      nt = notes.pop_front();
      check({pslverr, prdata & nt[31:0]}, {nt[64], nt[63:32] & nt[31:0]});
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [64:0] note);
    @(posedge clk);
    notes.push_back(note);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    {psel, pen} <= 2'b00;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic err);
    xfer(1'b0, a, 32'h0, {err, e, m});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 65'h0);
  endtask

  // bit 16 reads back nothing meaningful, so it is masked out
  task automatic rd_cw();
    rd(CW_A, {7'h0, mir[8], 1'b0, mir[6], refl, mir != ~ctl, chkf, det,
              sgn, mir[0], 7'h0, ctl}, 32'hfffeffff, 1'b0);
  endtask

  // junk in bits 15:9 must not stick
  task automatic wr_cw(input logic [8:0] cv, input logic [8:0] mv);
    wr(CW_A, {7'h0, mv, 7'($urandom), cv});
    {ctl, mir} = {cv, mv};
    if (!mv[2] && !above) det = 1'b0;
  endtask

  task automatic see(input logic [32:0] s, input logic [32:0] e);
    check(s, e);
    $display("test step done at %0t", $time);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      strobe <= 1'b1;
      idle(4);
      strobe <= 1'b0;
      idle(4);
    end
  endtask

  initial begin
    void'($urandom(32'h3ab513c7));
    {psel, pen, pwr, leak, above, strobe, neg, paddr, pwdata} = '0;
    {ctl, mir, refl, chkf, det, sgn, cfg_sum} = {CTRL_RST, MIRROR_RST, 4'h0, ALL_ONES};
    rst = 1'b1;
    idle(2);
    rst <= 1'b0;
    rd_cw();
    rd(SUM_A, CHKSUM_RST, ALL_ONES, 1'b0);
    @(negedge clk);
    check(ctrl_word, CTRL_RST);
    see(sc_fail, 1'b1);
    for (int i = 0; i < 8; i++) begin
      c = 9'($urandom);
      wr_cw(c, i[0] ? ~c : ~c ^ (9'h1 << i));
      rd_cw();
      @(negedge clk);
      check(sc_fail, mir != ~ctl);
      check(ctrl_word, ctl);
    end
    rd(12'h7cc, 32'h0, ALL_ONES, 1'b1);
    xfer(1'b1, CW_A + 12'h1, 32'h0, {1'b1, 64'h0});
    rd_cw();
    k = $urandom;
    cfg_sum <= ALL_ONES - k;
    wr(SUM_A, k);
    rd(SUM_A, k, ALL_ONES, 1'b0);
    rd_cw();
    cfg_sum <= ALL_ONES - k + 32'h1;
    chkf = 1'b1;
    idle(2);
    rd_cw();
    {leak, neg} <= 2'b11;
    {refl, sgn} = 2'b11;
    idle(4);
    rd_cw();
    wr_cw(ctl, ~ctl);
    rd_cw();
    neg <= 1'b0;
    sgn = 1'b0;
    idle(4);
    rd_cw();
    above <= 1'b1;
    idle(4);
    pulse(3);
    rd_cw();
    pulse(1);
    det = 1'b1;
    rd_cw();
    wr_cw(ctl, ~ctl & 9'h1fb);
    rd_cw();
    above <= 1'b0;
    idle(4);
    wr_cw(ctl, ~ctl | 9'h004);
    rd_cw();
    wr_cw(ctl, ~ctl & 9'h1fb);
    rd_cw();
    // a mask bit of one lets its status bit through to the interrupt
    @(negedge clk);
    check(irq, 1'b0);
    wr(MK_A, 32'hf);
    rd(ST_A, 32'hf, 32'hf, 1'b0);
    @(negedge clk);
    check(irq, 1'b1);
    wr(MK_A, 32'h8);
    idle(1);
    @(negedge clk);
    check(irq, 1'b1);
    wr(ST_A, 32'h8);
    idle(1);
    @(negedge clk);
    check(irq, 1'b0);
    rd(ST_A, 32'h7, 32'hf, 1'b0);
    wr(ST_A, 32'h7);
    rd(ST_A, 32'h0, 32'hf, 1'b0);
    rd(MK_A, 32'h8, 32'hf, 1'b0);
    idle(2);
    tally_and_finish();
  end

endmodule

`default_nettype wire
